// ---- rtl/damrc_ctrl.sv ----
// DRAM controller: address multiplexing, row and column strobes for two banks,
// internal or external refresh and arbitration against host accesses.
// Assumes host strobe, request and bank inputs meet setup to the falling clock edge.
`timescale 1ns/10ps
`default_nettype none

module damrc_ctrl (
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  input  wire logic                        refresh_mode_select,
  input  wire logic                        interval_or_refresh_req,
  input  wire logic                        mem_cycle_strobe_n,
  input  wire logic                        read_write_select,
  input  wire logic                        chip_select_n,
  input  wire logic                        bank_select,
  input  wire damrc_pkg::damrc_addr_type   row_addr_in,
  input  wire damrc_pkg::damrc_addr_type   col_addr_in,
  output var  damrc_pkg::damrc_addr_type   dram_addr_out,
  output var  damrc_pkg::damrc_strobe_type dram_strobe_n,
  output var  logic                        write_enable_n,
  output var  logic                        dram_oe_n,
  output var  logic                        ready
);

  // ****************************************************************
  // Falling-edge samples of host inputs
  // ****************************************************************
  logic as_fall_q;
  logic as_fall_d;
  logic req_fall_q;
  logic req_fall_d;
  logic bank_fall_q;
  logic bank_fall_d;

  always_comb begin
    as_fall_d   = mem_cycle_strobe_n;
    req_fall_d  = interval_or_refresh_req;
    bank_fall_d = bank_select;
  end

  always_ff @(negedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      as_fall_q   <= 1'b1;
      req_fall_q  <= 1'b1;
      bank_fall_q <= 1'b0;
    end else begin
      as_fall_q   <= as_fall_d;
      req_fall_q  <= req_fall_d;
      bank_fall_q <= bank_fall_d;
    end
  end

  // ****************************************************************
  // Mode select synchroniser and edge detect
  // ****************************************************************
  // Mode select is a slow strap-like pin, so it is synchronised rather than sampled.
  logic mode_s1_q;
  logic mode_s2_q;
  logic mode_prev_q;
  logic mode_fall;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_s1_q   <= 1'b0;
      mode_s2_q   <= 1'b0;
      mode_prev_q <= 1'b0;
    end else begin
      mode_s1_q   <= refresh_mode_select;
      mode_s2_q   <= mode_s1_q;
      mode_prev_q <= mode_s2_q;
    end
  end

  assign mode_fall = mode_prev_q & ~mode_s2_q;

  // ****************************************************************
  // Refresh request sources
  // ****************************************************************
  logic timer_tick;
  logic int_mode;
  logic pend_set;

  assign int_mode = mode_s2_q;

  damrc_refresh_timer u_timer (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .enable        (int_mode),
    .long_interval (req_fall_q),
    .tick_q        (timer_tick)
  );

  assign pend_set = int_mode ? timer_tick : ~req_fall_q;

  // ****************************************************************
  // Access and refresh sequencer
  // ****************************************************************
  damrc_pkg::damrc_state_type  state_q;
  damrc_pkg::damrc_state_type  state_d;
  damrc_pkg::damrc_strobe_type strobe_q;
  damrc_pkg::damrc_strobe_type strobe_d;
  damrc_pkg::damrc_addr_type   addr_q;
  damrc_pkg::damrc_addr_type   addr_d;
  damrc_pkg::damrc_addr_type   refcnt_q;
  damrc_pkg::damrc_addr_type   refcnt_d;
  logic [2:0]                  rascnt_q;
  logic [2:0]                  rascnt_d;
  logic                        ready_q;
  logic                        ready_d;
  logic                        pend_q;
  logic                        pend_d;
  logic                        pend_clr;

  always_comb begin
    state_d  = state_q;
    strobe_d = strobe_q;
    addr_d   = addr_q;
    refcnt_d = refcnt_q;
    rascnt_d = rascnt_q;
    ready_d  = ready_q;
    pend_clr = 1'b0;
    case (state_q)
      damrc_pkg::DAMRC_ST_IDLE, damrc_pkg::DAMRC_ST_REF_CHK: begin
        strobe_d = damrc_pkg::DAMRC_STROBE_IDLE;
        ready_d  = 1'b1;
        addr_d   = row_addr_in;
        if (!as_fall_q) begin
          state_d = damrc_pkg::DAMRC_ST_ROW;
          strobe_d.lower_row_strobe_n = bank_fall_q;
          strobe_d.upper_row_strobe_n = ~bank_fall_q;
        end else if (state_q == damrc_pkg::DAMRC_ST_REF_CHK) begin
          state_d  = damrc_pkg::DAMRC_ST_REF_ADDR;
          addr_d   = refcnt_q;
          ready_d  = 1'b0;
          pend_clr = 1'b1;
        end else if (pend_q) begin
          state_d = damrc_pkg::DAMRC_ST_REF_CHK;
        end
      end
      damrc_pkg::DAMRC_ST_ROW, damrc_pkg::DAMRC_ST_COL: begin
        if (as_fall_q) begin
          state_d  = damrc_pkg::DAMRC_ST_IDLE;
          strobe_d = damrc_pkg::DAMRC_STROBE_IDLE;
          addr_d   = row_addr_in;
        end else begin
          strobe_d.lower_row_strobe_n = bank_fall_q;
          strobe_d.upper_row_strobe_n = ~bank_fall_q;
          strobe_d.lower_col_strobe_n = 1'b0;
          strobe_d.upper_col_strobe_n = 1'b0;
          if (state_q == damrc_pkg::DAMRC_ST_ROW) begin
            addr_d = col_addr_in;
          end
          state_d = damrc_pkg::DAMRC_ST_COL;
        end
      end
      damrc_pkg::DAMRC_ST_REF_ADDR: begin
        strobe_d.lower_row_strobe_n = 1'b0;
        strobe_d.upper_row_strobe_n = 1'b0;
        strobe_d.lower_col_strobe_n = 1'b1;
        strobe_d.upper_col_strobe_n = 1'b1;
        rascnt_d = damrc_pkg::DAMRC_REF_RAS_LD;
        state_d  = damrc_pkg::DAMRC_ST_REF_RAS;
      end
      damrc_pkg::DAMRC_ST_REF_RAS: begin
        if (rascnt_q == 3'h0) begin
          strobe_d = damrc_pkg::DAMRC_STROBE_IDLE;
          ready_d  = 1'b1;
          addr_d   = row_addr_in;
          refcnt_d = refcnt_q + damrc_pkg::DAMRC_REFCNT_STEP;
          state_d  = damrc_pkg::DAMRC_ST_IDLE;
        end else begin
          rascnt_d = rascnt_q - 3'h1;
        end
      end
      default: begin
        state_d  = damrc_pkg::DAMRC_ST_IDLE;
        strobe_d = damrc_pkg::DAMRC_STROBE_IDLE;
        ready_d  = 1'b1;
      end
    endcase
    if (mode_fall) begin
      refcnt_d = damrc_pkg::DAMRC_REFCNT_INIT;
    end
    // A new request landing on the clear cycle is kept
    pend_d = pend_set | (pend_q & ~pend_clr);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= damrc_pkg::DAMRC_ST_IDLE;
      strobe_q <= damrc_pkg::DAMRC_STROBE_IDLE;
      addr_q   <= damrc_pkg::DAMRC_REFCNT_INIT;
      refcnt_q <= damrc_pkg::DAMRC_REFCNT_INIT;
      rascnt_q <= 3'h0;
      ready_q  <= 1'b1;
      pend_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      strobe_q <= strobe_d;
      addr_q   <= addr_d;
      refcnt_q <= refcnt_d;
      rascnt_q <= rascnt_d;
      ready_q  <= ready_d;
      pend_q   <= pend_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign dram_addr_out  = addr_q;
  assign dram_strobe_n  = strobe_q;
  assign ready          = ready_q;
  assign dram_oe_n      = chip_select_n;
  assign write_enable_n = read_write_select;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ready_low_bound: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(ready_q) |-> ##[1:10] ready_q)
    else $error("ready held low too long");

  a_row_after_sample: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == damrc_pkg::DAMRC_ST_IDLE && !as_fall_q)
      |=> (strobe_q.lower_row_strobe_n != strobe_q.upper_row_strobe_n))
    else $error("row strobe missing after access sample");

  a_col_follows_row: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == damrc_pkg::DAMRC_ST_ROW && !as_fall_q)
      |=> (!strobe_q.lower_col_strobe_n && !strobe_q.upper_col_strobe_n
           && addr_q == $past(col_addr_in)))
    else $error("column strobes or column address late");

  a_refresh_cols_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !ready_q |-> (strobe_q.lower_col_strobe_n && strobe_q.upper_col_strobe_n))
    else $error("column strobe active in refresh");

  a_refresh_rows_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == damrc_pkg::DAMRC_ST_REF_RAS)
      |-> (!strobe_q.lower_row_strobe_n && !strobe_q.upper_row_strobe_n && !ready_q))
    else $error("refresh without both row strobes");

  a_refresh_addr_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(ready_q) |-> (addr_q == refcnt_q && strobe_q.lower_row_strobe_n)
      ##1 !strobe_q.lower_row_strobe_n)
    else $error("refresh address not ahead of row strobes");

  a_count_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($rose(ready_q) && !$past(mode_fall))
      |-> refcnt_q == $past(refcnt_q) + damrc_pkg::DAMRC_REFCNT_STEP)
    else $error("refresh counter did not step by one");

  a_mode_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode_fall |=> refcnt_q == damrc_pkg::DAMRC_REFCNT_INIT)
    else $error("mode fall did not clear counter");

  a_access_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == damrc_pkg::DAMRC_ST_COL && as_fall_q)
      |=> (strobe_q == damrc_pkg::DAMRC_STROBE_IDLE && ready_q))
    else $error("strobes not released or refresh cut into access");

  // An access sampled at either of the next two falling edges legally goes first
  a_ext_refresh_bound: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!int_mode && !req_fall_q && state_q == damrc_pkg::DAMRC_ST_IDLE && as_fall_q)
      ##1 as_fall_q ##1 as_fall_q |-> ##[0:1] !ready_q)
    else $error("external refresh did not start");

endmodule

`default_nettype wire

// ---- include/damrc_pkg.sv ----
// Shared constants and types for the DRAM address multiplexer and refresh controller.
// Assumes one system clock; all counts below are in cycles of that clock.
package damrc_pkg;

  // ****************************************************************
  // Widths, reset values and counter step
  // ****************************************************************
  localparam int unsigned DAMRC_ADDR_W      = 9;
  localparam logic [8:0]  DAMRC_REFCNT_INIT = 9'h000;
  localparam logic [8:0]  DAMRC_REFCNT_STEP = 9'h001;

  // ****************************************************************
  // Refresh interval and refresh cycle timing
  // ****************************************************************
  localparam logic [8:0]  DAMRC_INT_SHORT_CYC = 9'h0E8;
  localparam logic [8:0]  DAMRC_INT_LONG_CYC  = 9'h174;
  localparam logic [8:0]  DAMRC_INT_SHORT_LD  = DAMRC_INT_SHORT_CYC - 9'h001;
  localparam logic [8:0]  DAMRC_INT_LONG_LD   = DAMRC_INT_LONG_CYC - 9'h001;
  localparam logic [2:0]  DAMRC_REF_RAS_CYC   = 3'h6;
  localparam logic [2:0]  DAMRC_REF_RAS_LD    = DAMRC_REF_RAS_CYC - 3'h1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [DAMRC_ADDR_W-1:0] damrc_addr_type;

  typedef struct packed {
    logic lower_row_strobe_n;
    logic upper_row_strobe_n;
    logic lower_col_strobe_n;
    logic upper_col_strobe_n;
  } damrc_strobe_type;

  localparam damrc_strobe_type DAMRC_STROBE_IDLE = 4'hF;

  typedef enum logic [5:0] {
    DAMRC_ST_IDLE     = 6'h01,
    DAMRC_ST_ROW      = 6'h02,
    DAMRC_ST_COL      = 6'h04,
    DAMRC_ST_REF_CHK  = 6'h08,
    DAMRC_ST_REF_ADDR = 6'h10,
    DAMRC_ST_REF_RAS  = 6'h20
  } damrc_state_type;

endpackage

// ---- rtl/damrc_refresh_timer.sv ----
// Internal refresh interval timer: one-cycle tick per refresh interval.
// Assumes enable and interval select come from logic on clk_sys.
`timescale 1ns/10ps
`default_nettype none

module damrc_refresh_timer (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic enable,
  input  wire logic long_interval,
  output var  logic tick_q
);

  logic [8:0] count_q;
  logic [8:0] count_d;
  logic       tick_d;
  logic [8:0] reload;

  // ****************************************************************
  // Interval counter
  // ****************************************************************
  always_comb begin
    reload  = long_interval ? damrc_pkg::DAMRC_INT_LONG_LD : damrc_pkg::DAMRC_INT_SHORT_LD;
    count_d = count_q;
    tick_d  = 1'b0;
    if (!enable) begin
      count_d = reload;
    end else if (count_q == 9'h000) begin
      count_d = reload;
      tick_d  = 1'b1;
    end else begin
      count_d = count_q - 9'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= damrc_pkg::DAMRC_INT_SHORT_LD;
      tick_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q  <= tick_d;
    end
  end

  // ****************************************************************
  // Check helpers
  // ****************************************************************
  // A gap counter keeps the period checks cheap; a long repetition would not be
  logic [8:0] gap_q;
  logic [8:0] gap_d;
  logic       prev_long_q;
  logic       prev_long_d;
  logic       per_long_q;
  logic       per_long_d;
  logic       per_valid_q;
  logic       per_valid_d;

  always_comb begin
    gap_d       = gap_q;
    prev_long_d = long_interval;
    per_long_d  = per_long_q;
    per_valid_d = per_valid_q;
    if (!enable) begin
      gap_d       = 9'h000;
      per_valid_d = 1'b0;
    end else if (tick_q) begin
      // Period of the next gap was chosen in the cycle before this tick
      gap_d       = 9'h001;
      per_long_d  = prev_long_q;
      per_valid_d = 1'b1;
    end else if (gap_q != 9'h1FF) begin
      gap_d = gap_q + 9'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap_q       <= 9'h000;
      prev_long_q <= 1'b0;
      per_long_q  <= 1'b0;
      per_valid_q <= 1'b0;
    end else begin
      gap_q       <= gap_d;
      prev_long_q <= prev_long_d;
      per_long_q  <= per_long_d;
      per_valid_q <= per_valid_d;
    end
  end

  a_tick_spacing_short: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tick_q |=> !tick_q [*8])
    else $error("refresh ticks too close together");

  a_tick_period_short: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (per_valid_q && !per_long_q && gap_q == damrc_pkg::DAMRC_INT_SHORT_CYC) |-> tick_q)
    else $error("short refresh interval missed its tick");

  a_tick_period_long: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (per_valid_q && per_long_q && gap_q == damrc_pkg::DAMRC_INT_LONG_CYC) |-> tick_q)
    else $error("long refresh interval missed its tick");

  a_tick_period_exact: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (tick_q && per_valid_q)
      |-> gap_q == (per_long_q ? damrc_pkg::DAMRC_INT_LONG_CYC : damrc_pkg::DAMRC_INT_SHORT_CYC))
    else $error("refresh tick came early");

endmodule

`default_nettype wire

// ---- verification/damrc_dram_model.sv ----
// Passive model of two DRAM banks on the controller's memory side.
// Assumes strobes and address change on rising clk_sys edges only.
`timescale 1ns/10ps
`default_nettype none

module damrc_dram_model (
  input  wire logic                        clk_sys,
  input  wire damrc_pkg::damrc_addr_type   dram_addr_out,
  input  wire damrc_pkg::damrc_strobe_type dram_strobe_n,
  input  wire logic                        dram_oe_n,
  output var  damrc_pkg::damrc_addr_type   lat_row_lo,
  output var  damrc_pkg::damrc_addr_type   lat_row_hi,
  output var  damrc_pkg::damrc_addr_type   lat_col,
  output var  damrc_pkg::damrc_addr_type   lat_ref
);
  damrc_pkg::damrc_strobe_type s;
  damrc_pkg::damrc_strobe_type p;

  // Floating strobe lines sit on pull-ups, so a released bus reads high
  assign s = dram_oe_n ? damrc_pkg::DAMRC_STROBE_IDLE : dram_strobe_n;

  // Sample mid-cycle so the rising-edge updates have settled
  always @(negedge clk_sys) begin
    // both rows fall with columns high
    if (p[3] && p[2] && !s[3] && !s[2] && s[1] && s[0])
      lat_ref = dram_addr_out;
    else if (p[3] && !s[3])
      lat_row_lo = dram_addr_out;
    else if (p[2] && !s[2])
      lat_row_hi = dram_addr_out;
    if (p[1] && !s[1])
      lat_col = dram_addr_out;
    p = s;
  end

  initial p = damrc_pkg::DAMRC_STROBE_IDLE;
endmodule

`default_nettype wire

// ---- verification/damrc_ctrl_tb.sv ----
// Self-checking bench for the DRAM controller top.
// Assumes the design package is compiled first; inputs move 10 ns after rising edges.
`timescale 1ns/10ps
`default_nettype none

module damrc_ctrl_tb;
  logic                        clk_sys, reset_n, refresh_mode_select, interval_or_refresh_req;
  logic                        mem_cycle_strobe_n, read_write_select, chip_select_n, bank_select;
  damrc_pkg::damrc_addr_type   row_addr_in, col_addr_in, dram_addr_out;
  damrc_pkg::damrc_addr_type   lat_row_lo, lat_row_hi, lat_col, lat_ref;
  damrc_pkg::damrc_strobe_type dram_strobe_n;
  logic                        write_enable_n, dram_oe_n, ready;
  logic [8:0]                  exp_cnt;
  int                          num_errors, n_compared, cyc_cnt, t_fall, t0;

  damrc_ctrl u_damrc_ctrl (.clk_sys(clk_sys), .reset_n(reset_n),
    .refresh_mode_select(refresh_mode_select), .interval_or_refresh_req(interval_or_refresh_req),
    .mem_cycle_strobe_n(mem_cycle_strobe_n), .read_write_select(read_write_select),
    .chip_select_n(chip_select_n), .bank_select(bank_select), .row_addr_in(row_addr_in),
    .col_addr_in(col_addr_in), .dram_addr_out(dram_addr_out), .dram_strobe_n(dram_strobe_n),
    .write_enable_n(write_enable_n), .dram_oe_n(dram_oe_n), .ready(ready));

  damrc_dram_model u_damrc_dram_model (.clk_sys(clk_sys), .dram_addr_out(dram_addr_out),
    .dram_strobe_n(dram_strobe_n), .dram_oe_n(dram_oe_n), .lat_row_lo(lat_row_lo),
    .lat_row_hi(lat_row_hi), .lat_col(lat_col), .lat_ref(lat_ref));

  // ****************************************************************
  // Clock, cycle count and watchdog
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) cyc_cnt++;

  // About 6500 cycles are expected; the limit of 20000 cycles leaves wide margin
  initial begin
    #2000000;
    num_errors++;
    print_verdict();
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic acc_start(input logic b, input logic rw, input logic [8:0] r, input logic [8:0] c);
    bank_select = b; // bank held while strobe low
    read_write_select = rw;
    row_addr_in = r;
    col_addr_in = c;
    mem_cycle_strobe_n = 1'b0;
  endtask

  task automatic acc_check(input logic b, input logic rw, input logic [8:0] r, input logic [8:0] c);
    cyc(1);
    check("row strobe", 16'(dram_strobe_n), b ? 16'hB : 16'h7);
    check("row addr", 16'(dram_addr_out), 16'(r));
    cyc(1);
    check("col strobe", 16'(dram_strobe_n), b ? 16'h8 : 16'h4);
    check("col addr", 16'(dram_addr_out), 16'(c));
    check("write enable", 16'(write_enable_n), 16'(rw));
    read_write_select = ~rw;
    #1;
    check("late write", 16'(write_enable_n), 16'(!rw));
    read_write_select = rw;
    cyc(2); // strobe held for pulse width
    check("col held", 16'(dram_strobe_n), b ? 16'h8 : 16'h4);
    mem_cycle_strobe_n = 1'b1;
    cyc(1);
    check("release", 16'(dram_strobe_n), 16'hF);
    check("dram row", 16'(b ? lat_row_hi : lat_row_lo), 16'(r));
    check("dram col", 16'(lat_col), 16'(c));
  endtask

  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (ready !== 1'b0 && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) check("ready timeout", 16'h1, 16'h0);
    t_fall = cyc_cnt;
  endtask

  // Entered at the first cycle with ready low; optionally starts an access that waits out the refresh
  task automatic refresh_body(input logic acc);
    int n;
    n = 0;
    check("ref addr", 16'(dram_addr_out), 16'(exp_cnt));
    check("ref pre", 16'(dram_strobe_n), 16'hF);
    if (acc) acc_start(1'b1, 1'b0, 9'h0C3, 9'h13C);
    while (ready === 1'b0 && n < 12) begin
      if (n > 0) check("ref strobe", 16'(dram_strobe_n), 16'h3);
      n++;
      cyc(1);
    end
    check("ready span", 16'(n), 16'd7);
    check("ref end", 16'(dram_strobe_n), 16'hF);
    check("dram ref", 16'(lat_ref), 16'(exp_cnt));
    exp_cnt = exp_cnt + 9'h001;
  endtask

  task automatic ext_refresh(input logic acc);
    interval_or_refresh_req = 1'b0;
    cyc(1);
    interval_or_refresh_req = 1'b1;
    wait_ready(4);
    refresh_body(acc);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {reset_n, refresh_mode_select, bank_select, chip_select_n} = 4'h0;
    {interval_or_refresh_req, mem_cycle_strobe_n, read_write_select} = 3'h7;
    row_addr_in = 9'h000;
    col_addr_in = 9'h000;
    exp_cnt = 9'h000;
    repeat (5) @(posedge clk_sys);
    #10;
    reset_n = 1'b1;
    cyc(1);
    check("ready idle", 16'(ready), 16'h1);
    check("idle strobes", 16'(dram_strobe_n), 16'hF);
    acc_start(1'b0, 1'b1, 9'h155, 9'h0AA);
    acc_check(1'b0, 1'b1, 9'h155, 9'h0AA);
    acc_start(1'b1, 1'b0, 9'h1FF, 9'h000);
    acc_check(1'b1, 1'b0, 9'h1FF, 9'h000);
    chip_select_n = 1'b1;
    #1;
    check("float", 16'({dram_oe_n, ready}), 16'h3);
    chip_select_n = 1'b0;
    #1;
    check("drive", 16'(dram_oe_n), 16'h0);
    ext_refresh(1'b0);
    ext_refresh(1'b1);
    acc_check(1'b1, 1'b0, 9'h0C3, 9'h13C);
    // Request taken with the access strobe: the access goes first
    acc_start(1'b0, 1'b1, 9'h0F0, 9'h10F);
    interval_or_refresh_req = 1'b0;
    cyc(1);
    interval_or_refresh_req = 1'b1;
    repeat (4) begin
      check("ready held", 16'(ready), 16'h1);
      cyc(1);
    end
    check("access first", 16'(dram_strobe_n), 16'h4);
    mem_cycle_strobe_n = 1'b1;
    wait_ready(6);
    refresh_body(1'b0);
    repeat (512) ext_refresh(1'b0);
    // Internal mode, long interval first since a high request line selects the long interval
    refresh_mode_select = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wait_ready(1000);
      refresh_body(1'b0);
      t0 = t_fall;
      wait_ready(1000);
      refresh_body(1'b0);
      check("interval", 16'(t_fall - t0), i == 0 ? 16'd372 : 16'd232);
      interval_or_refresh_req = 1'b0;
    end
    interval_or_refresh_req = 1'b1;
    refresh_mode_select = 1'b0;
    cyc(4);
    exp_cnt = 9'h000;
    ext_refresh(1'b0);
    print_verdict();
  end
endmodule

`default_nettype wire
